// File: hdlc_assist_pkg.sv
// Purpose: constants for the framing assist block
// Assumes: 8-bit external data memory bus, one clock
// Notes:   offsets are the controller byte addresses
//
// Functional notes
// - go write runs staged bits through deframer
// - deframer discards flag octets, keeps frame data
// - 21-byte receive FIFO read at staging address
// - bit-count write makes framer shift that many bits, up to 128
// - empty transmit FIFO makes framer send flags
// - insert zero after five ones in data
// - 21-byte transmit FIFO feeds the framer
// - framer output bits fill 16-byte readable buffer
// - ready clears after drain and flag, sets at threshold
// - firmware sets loaded, device clears when consumed
// - threshold select: 0 is 11, 1 is 16
// - level bit 0 at or above threshold
// - done cleared by count write, set on match
// - receive empty bit mirrors zero FIFO count
// - control reset bit resets framing circuit
// - check input write, result read, same address
// - result ready set on load, cleared by read
// - frame end flag sticky until reset
// - frame good flag reports check pass
// - input empty flag cleared by write
// - status top bit write resets check unit
// - check value low then high byte readable
package hdlc_assist_pkg;
	// ==========================================
	// addresses
	localparam logic [15:0] ADDR_RX_GO    = 16'hdc00;
	localparam logic [15:0] ADDR_RX_DATA  = 16'hdc01;
	localparam logic [15:0] ADDR_TX_COUNT = 16'hdc02;
	localparam logic [15:0] ADDR_TX_DATA  = 16'hdc03;
	localparam logic [15:0] ADDR_CTRL     = 16'hdc04;
	localparam logic [15:0] ADDR_CHK_DATA = 16'hdc08;
	localparam logic [15:0] ADDR_CHK_STAT = 16'hdc09;
	localparam logic [15:0] ADDR_CHK_LOW  = 16'hdc0a;
	localparam logic [15:0] ADDR_CHK_HIGH = 16'hdc0b;
	// ==========================================
	// control/status bit positions
	localparam int CTL_THR_SEL    = 2;
	localparam int CTL_RX_LOADED  = 1;
	localparam int CTL_RESET      = 6;
	localparam int CHK_RESET      = 7;
	// ==========================================
	// sizes and counts
	localparam int           FIFO_DEPTH = 21;
	localparam int           BUF_BYTES  = 16;
	localparam logic [7:0]   BUF_BITS   = 8'h80;
	localparam logic [4:0]   THR_LOW    = 5'h0b;
	localparam logic [4:0]   THR_HIGH   = 5'h10;
	localparam logic [7:0]   FLAG_OCTET = 8'h7e;
	localparam logic [2:0]   STUFF_RUN  = 3'h5;
	localparam logic [3:0]   WIN_FULL   = 4'h8;
	localparam logic [3:0]   WIN_NEAR   = 4'h7;
	// ==========================================
	// frame check
	localparam logic [15:0]  CRC_POLY_REV = 16'h8408;
	localparam logic [15:0]  CRC_INIT     = 16'hffff;
	localparam logic [15:0]  CRC_GOOD     = 16'hf0b8;
	localparam logic [7:0]   RD_IDLE      = 8'h00;
endpackage : hdlc_assist_pkg

// File: hdlc_framing_assist.sv
// Purpose: framing assist with receive deframer, transmit framer, check unit
// Assumes: bus strobes synchronous to clk, one access per strobe
// Notes:   data_out/data_oe form the bus data pin with data_in
`timescale 1ns/1ps

// ==========================================
// byte fifo
module byte_fifo #(
	parameter int DEPTH = 21
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       push,
	input  wire logic [7:0] din,
	input  wire logic       pop,
	output logic      [7:0] dout,
	output logic      [4:0] count
);
	logic [7:0] mem [DEPTH];
	logic [4:0] wp;
	logic [4:0] rp;
	wire        do_push = push & (count != 5'(DEPTH));
	wire        do_pop  = pop & (count != 5'h00);
	assign dout = mem[rp];
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp] <= din;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp    <= 5'h00;
			rp    <= 5'h00;
			count <= 5'h00;
		end else begin
			if (do_push) begin
				wp <= (wp == 5'(DEPTH - 1)) ? 5'h00 : wp + 5'h01;
			end
			if (do_pop) begin
				rp <= (rp == 5'(DEPTH - 1)) ? 5'h00 : rp + 5'h01;
			end
			count <= count + 5'(do_push) - 5'(do_pop);
		end
	end
endmodule : byte_fifo

// ==========================================
// top
module hdlc_framing_assist
	import hdlc_assist_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  data_in,
	input  wire logic        wr_n,
	input  wire logic        rd_n,
	output logic      [7:0]  data_out,
	output logic             data_oe
);
	// ==========================================
	// bus strobes and decode
	logic wr_q;
	logic rd_q;
	wire  wr_go    = wr_q & ~wr_n;
	wire  rd_go    = rd_q & ~rd_n;
	wire  s_rx_go  = addr == ADDR_RX_GO;
	wire  s_rx_dat = addr == ADDR_RX_DATA;
	wire  s_tx_cnt = addr == ADDR_TX_COUNT;
	wire  s_tx_dat = addr == ADDR_TX_DATA;
	wire  s_ctrl   = addr == ADDR_CTRL;
	wire  s_c_dat  = addr == ADDR_CHK_DATA;
	wire  s_c_stat = addr == ADDR_CHK_STAT;
	wire  s_c_low  = addr == ADDR_CHK_LOW;
	wire  s_c_high = addr == ADDR_CHK_HIGH;
	wire  s_any    = s_rx_go | s_rx_dat | s_tx_cnt | s_tx_dat | s_ctrl
	               | s_c_dat | s_c_stat | s_c_low | s_c_high;
	wire  w_rx_go  = wr_go & s_rx_go;
	wire  w_rx_dat = wr_go & s_rx_dat;
	wire  w_tx_cnt = wr_go & s_tx_cnt;
	wire  w_tx_dat = wr_go & s_tx_dat;
	wire  w_ctrl   = wr_go & s_ctrl;
	wire  w_c_dat  = wr_go & s_c_dat;
	wire  w_c_stat = wr_go & s_c_stat;
	wire  r_rx_dat = rd_go & s_rx_dat;
	wire  r_tx_dat = rd_go & s_tx_dat;
	wire  r_c_dat  = rd_go & s_c_dat;

	// ==========================================
	// control bits and local resets
	logic thr_sel;
	logic ctl_rst;
	logic fr_n;
	logic chk_n;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_q    <= 1'b1;
			rd_q    <= 1'b1;
			thr_sel <= 1'b0;
			ctl_rst <= 1'b0;
			fr_n    <= 1'b0;
			chk_n   <= 1'b0;
		end else begin
			wr_q    <= wr_n;
			rd_q    <= rd_n;
			thr_sel <= w_ctrl ? data_in[CTL_THR_SEL] : thr_sel;
			ctl_rst <= w_ctrl ? data_in[CTL_RESET] : ctl_rst;
			fr_n    <= ~ctl_rst;
			chk_n   <= ~(w_c_stat & data_in[CHK_RESET]);
		end
	end

	// ==========================================
	// receive staging and deframer
	logic [7:0] stage [BUF_BYTES];
	logic [3:0] stage_wp;
	logic [7:0] rx_bits;
	logic [7:0] rx_bp;
	logic       rx_act;
	logic       rx_loaded;
	logic [7:0] win;
	logic [3:0] win_n;
	logic [2:0] ones_rx;
	logic [7:0] acc;
	logic [2:0] acc_n;
	logic [7:0] rx_dout;
	logic [4:0] rx_cnt;
	wire        rx_bit   = stage[rx_bp[6:3]][rx_bp[2:0]];
	wire        rx_end   = rx_act & ((rx_bp + 8'h01 == rx_bits) | (rx_bp == BUF_BITS - 8'h01));
	wire [7:0]  next_win = {rx_bit, win[7:1]};
	wire        flag_hit = rx_act & (win_n >= WIN_NEAR) & (next_win == FLAG_OCTET);
	wire        out_v    = rx_act & (win_n == WIN_FULL);
	wire        out_bit  = win[0];
	wire        ds_drop  = out_v & (ones_rx == STUFF_RUN) & ~out_bit;
	wire        take     = out_v & ~ds_drop;
	wire [7:0]  next_acc = {out_bit, acc[7:1]};
	wire        byte_rdy = take & (acc_n == 3'h7);
	wire        rx_empty = rx_cnt == 5'h00;

	always_ff @(posedge clk) begin
		if (w_rx_dat) begin
			stage[stage_wp] <= data_in;
		end
	end

	always_ff @(posedge clk or negedge fr_n) begin
		if (!fr_n) begin
			stage_wp  <= 4'h0;
			rx_bits   <= 8'h00;
			rx_bp     <= 8'h00;
			rx_act    <= 1'b0;
			rx_loaded <= 1'b0;
			win       <= 8'h00;
			win_n     <= 4'h0;
			ones_rx   <= 3'h0;
			acc       <= 8'h00;
			acc_n     <= 3'h0;
		end else begin
			if (w_rx_dat) begin
				stage_wp <= stage_wp + 4'h1;
			end else if (rx_end) begin
				stage_wp <= 4'h0;
			end
			if (w_rx_go) begin
				rx_bits <= data_in;
				rx_bp   <= 8'h00;
				rx_act  <= data_in != 8'h00;
			end else if (rx_act) begin
				rx_bp  <= rx_bp + 8'h01;
				rx_act <= ~rx_end;
			end
			if (w_ctrl) begin
				rx_loaded <= data_in[CTL_RX_LOADED];
			end else if (rx_end) begin
				rx_loaded <= 1'b0;
			end
			if (rx_act) begin
				win <= next_win;
			end
			if (flag_hit) begin
				win_n <= 4'h0;
			end else if (rx_act & (win_n != WIN_FULL)) begin
				win_n <= win_n + 4'h1;
			end
			if (flag_hit) begin
				ones_rx <= 3'h0;
			end else if (out_v) begin
				ones_rx <= !out_bit ? 3'h0 : (ones_rx == STUFF_RUN) ? STUFF_RUN : ones_rx + 3'h1;
			end
			if (take) begin
				acc <= next_acc;
			end
			if (flag_hit & ~byte_rdy) begin
				acc_n <= 3'h0;
			end else if (take) begin
				acc_n <= acc_n + 3'h1;
			end
		end
	end

	AST_RX_FLAG_DROP: assert property (@(posedge clk) disable iff (!fr_n)
		flag_hit |=> win_n == 4'h0) else $error("flag octet not discarded");
	AST_RX_LOADED_CLR: assert property (@(posedge clk) disable iff (!fr_n)
		rx_end && !w_ctrl |=> !rx_loaded && !rx_act) else $error("loaded bit not cleared");
	AST_RX_COUNT: assert property (@(posedge clk) disable iff (!fr_n)
		w_rx_go && data_in == 8'h03 |=> rx_act [*3] ##1 !rx_act) else $error("bit count wrong");

	byte_fifo #(.DEPTH(FIFO_DEPTH)) rx_fifo (
		.clk   (clk),
		.rstn  (fr_n),
		.push  (byte_rdy),
		.din   (next_acc),
		.pop   (r_rx_dat),
		.dout  (rx_dout),
		.count (rx_cnt)
	);

	// ==========================================
	// transmit framer
	logic [7:0] outbuf [BUF_BYTES];
	logic [3:0] tx_rp;
	logic [7:0] tx_bits;
	logic [7:0] tx_op;
	logic       tx_arm;
	logic [7:0] tx_sh;
	logic [3:0] tx_sn;
	logic       tx_is_flag;
	logic [2:0] ones_tx;
	logic       tx_done;
	logic       tx_ready;
	logic [7:0] tx_dout;
	logic [4:0] tx_cnt;
	wire [4:0]  thr      = thr_sel ? THR_HIGH : THR_LOW;
	wire        tx_full  = tx_cnt >= thr;
	wire        tx_level = ~tx_full;
	wire        tx_run   = tx_arm & (tx_op != tx_bits) & (tx_op != BUF_BITS);
	wire        tx_load  = tx_run & (tx_sn == 4'h0);
	wire        tx_fetch = tx_load & (tx_cnt != 5'h00);
	wire        tx_emit  = tx_run & (tx_sn != 4'h0);
	wire        tx_stuff = tx_emit & ~tx_is_flag & (ones_tx == STUFF_RUN);
	wire        tx_bit   = tx_stuff ? 1'b0 : tx_sh[0];
	wire        flag_out = tx_emit & tx_is_flag & (tx_sn == 4'h1);

	always_ff @(posedge clk) begin
		if (tx_emit) begin
			outbuf[tx_op[6:3]][tx_op[2:0]] <= tx_bit;
		end
	end

	always_ff @(posedge clk or negedge fr_n) begin
		if (!fr_n) begin
			tx_rp      <= 4'h0;
			tx_bits    <= 8'h00;
			tx_op      <= 8'h00;
			tx_arm     <= 1'b0;
			tx_sh      <= 8'h00;
			tx_sn      <= 4'h0;
			tx_is_flag <= 1'b0;
			ones_tx    <= 3'h0;
			tx_done    <= 1'b0;
			tx_ready   <= 1'b0;
		end else begin
			if (w_tx_cnt) begin
				tx_bits <= data_in;
				tx_op   <= 8'h00;
				tx_rp   <= 4'h0;
				tx_arm  <= 1'b1;
			end else begin
				tx_op <= tx_emit ? tx_op + 8'h01 : tx_op;
				tx_rp <= r_tx_dat ? tx_rp + 4'h1 : tx_rp;
			end
			if (tx_load) begin
				tx_sh      <= tx_fetch ? tx_dout : FLAG_OCTET;
				tx_is_flag <= ~tx_fetch;
				tx_sn      <= WIN_FULL;
			end else if (tx_emit & ~tx_stuff) begin
				tx_sh <= {1'b0, tx_sh[7:1]};
				tx_sn <= tx_sn - 4'h1;
			end
			if (tx_emit) begin
				ones_tx <= (tx_is_flag | ~tx_bit) ? 3'h0 : ones_tx + 3'h1;
			end
			if (w_tx_cnt) begin
				tx_done <= 1'b0;
			end else if (tx_arm & (tx_op == tx_bits)) begin
				tx_done <= 1'b1;
			end
			if (tx_full) begin
				tx_ready <= 1'b1;
			end else if (flag_out & (tx_cnt == 5'h00)) begin
				tx_ready <= 1'b0;
			end
		end
	end

	AST_TX_STUFF: assert property (@(posedge clk) disable iff (!fr_n)
		tx_emit && !tx_is_flag && ones_tx == 3'h5 |-> !tx_bit ##1 ones_tx == 3'h0)
		else $error("zero not inserted");
	AST_TX_IDLE_FLAG: assert property (@(posedge clk) disable iff (!fr_n)
		tx_load && tx_cnt == 5'h00 |=> tx_sh == 8'h7e && tx_is_flag && tx_sn == 4'h8)
		else $error("idle flag not loaded");
	AST_TX_DONE: assert property (@(posedge clk) disable iff (!fr_n)
		w_tx_cnt && data_in == 8'h02 |=> !tx_done ##[1:8] tx_done && tx_op == 8'h02)
		else $error("done bit wrong");
	AST_TX_BITS: assert property (@(posedge clk) disable iff (!fr_n)
		tx_arm && tx_op == tx_bits |=> $stable(tx_op) || $past(w_tx_cnt))
		else $error("framer ran past bit count");
	AST_TX_READY: assert property (@(posedge clk) disable iff (!fr_n)
		tx_cnt >= (thr_sel ? 5'h10 : 5'h0b) |=> tx_ready)
		else $error("ready not set at threshold");
	AST_TX_LEVEL: assert property (@(posedge clk) disable iff (!fr_n)
		!thr_sel && tx_cnt == 5'h0a |-> tx_level)
		else $error("level bit wrong below threshold");

	byte_fifo #(.DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk   (clk),
		.rstn  (fr_n),
		.push  (w_tx_dat),
		.din   (data_in),
		.pop   (tx_fetch),
		.dout  (tx_dout),
		.count (tx_cnt)
	);

	// ==========================================
	// check unit
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	logic [7:0]  in_hold;
	logic        in_empty;
	logic [7:0]  res;
	logic        res_rdy;
	logic        f_end;
	logic        f_good;
	logic        f_open;
	logic [15:0] crc;
	wire         consume = ~in_empty;
	wire         is_flag = in_hold == FLAG_OCTET;
	wire         load    = consume & ~is_flag;
	wire [15:0]  crc_val = ~crc;

	always_ff @(posedge clk or negedge chk_n) begin
		if (!chk_n) begin
			in_hold  <= 8'h00;
			in_empty <= 1'b1;
			res      <= 8'h00;
			res_rdy  <= 1'b0;
			f_end    <= 1'b0;
			f_good   <= 1'b0;
			f_open   <= 1'b0;
			crc      <= CRC_INIT;
		end else begin
			if (w_c_dat) begin
				in_hold  <= data_in;
				in_empty <= 1'b0;
			end else if (consume) begin
				in_empty <= 1'b1;
			end
			if (load) begin
				res     <= in_hold;
				res_rdy <= 1'b1;
				crc     <= crc_step(crc, in_hold);
				f_open  <= 1'b1;
			end else if (r_c_dat) begin
				res_rdy <= 1'b0;
			end
			if (consume & is_flag & f_open) begin
				f_end  <= 1'b1;
				f_good <= crc == CRC_GOOD;
				f_open <= 1'b0;
				crc    <= CRC_INIT;
			end
		end
	end

	AST_CHK_READY: assert property (@(posedge clk) disable iff (!chk_n)
		r_c_dat && !load |=> !res_rdy) else $error("ready not cleared by read");
	AST_CHK_IN_EMPTY: assert property (@(posedge clk) disable iff (!chk_n)
		w_c_dat |=> !in_empty ##1 in_empty || $past(w_c_dat))
		else $error("input empty flag wrong");
	AST_CHK_END_STICKY: assert property (@(posedge clk) disable iff (!chk_n)
		f_end |=> f_end) else $error("frame end flag dropped");
	AST_CHK_GOOD: assert property (@(posedge clk) disable iff (!chk_n)
		consume && is_flag && f_open |=> f_end && f_good == ($past(crc) == 16'hf0b8))
		else $error("frame good flag wrong");

	// ==========================================
	// read path
	wire [7:0] ctrl_rd = {1'b0, ctl_rst, rx_empty, tx_done, tx_level, thr_sel, rx_loaded, tx_ready};
	wire [7:0] chk_rd  = {4'h0, in_empty, f_good, f_end, res_rdy};
	wire [7:0] rd_val  = s_rx_dat ? rx_dout
	                   : s_tx_dat ? outbuf[tx_rp]
	                   : s_ctrl   ? ctrl_rd
	                   : s_c_dat  ? res
	                   : s_c_stat ? chk_rd
	                   : s_c_low  ? crc_val[7:0]
	                   : s_c_high ? crc_val[15:8]
	                   : RD_IDLE;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else begin
			data_out <= rd_go ? rd_val : data_out;
			data_oe  <= ~rd_n & s_any;
		end
	end

	AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!resetn)
		w_ctrl && data_in[6] |=> ##1 !fr_n ##1 tx_cnt == 5'h00 && rx_cnt == 5'h00)
		else $error("framer reset not applied");
	AST_CHK_RESET: assert property (@(posedge clk) disable iff (!resetn)
		w_c_stat && data_in[7] |=> !chk_n ##1 !f_end && in_empty)
		else $error("check unit reset not applied");
	AST_RX_EMPTY: assert property (@(posedge clk) disable iff (!resetn)
		rd_go && s_ctrl |=> data_out[5] == ($past(rx_cnt) == 5'h00))
		else $error("receive empty bit wrong");
endmodule : hdlc_framing_assist

// File: tb_top.sv
// Purpose: self-checking bench for the framing assist block
// Assumes: bus strobes driven at the falling edge, one access per strobe
// Notes:   ordinary cases run from a row table, then hand-written cases
`timescale 1ns/1ps

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
	$display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb_top;
	import hdlc_assist_pkg::*;

	// ==========================================
	// signals
	logic        clk;
	logic        resetn;
	logic [15:0] addr;
	logic [7:0]  data_in;
	logic        wr_n;
	logic        rd_n;
	logic [7:0]  data_out;
	logic        data_oe;
	int          fail_count;
	int          compares;

	// kind: 0 read, 1 write, 2 idle cycles, 3 unmapped read
	typedef struct packed {
		logic [1:0]  kind;
		logic [15:0] a;
		logic [7:0]  d;
		logic [7:0]  m;
	} op_t;

	op_t rows [27] = '{
		'{2'd0, ADDR_CTRL, 8'h28, 8'h2e},
		'{2'd0, ADDR_CHK_STAT, 8'h08, 8'h0b},
		'{2'd3, 16'hdc05, 8'h00, 8'h00},
		'{2'd1, ADDR_TX_COUNT, 8'h08, 8'h00},
		'{2'd0, ADDR_CTRL, 8'h00, 8'h10},
		'{2'd2, 16'h0000, 8'h14, 8'h00},
		'{2'd0, ADDR_CTRL, 8'h10, 8'h11},
		'{2'd0, ADDR_TX_DATA, 8'h7e, 8'hff},
		'{2'd1, ADDR_TX_DATA, 8'hff, 8'h00},
		'{2'd1, ADDR_TX_COUNT, 8'h08, 8'h00},
		'{2'd2, 16'h0000, 8'h14, 8'h00},
		'{2'd0, ADDR_TX_DATA, 8'hdf, 8'hff},
		'{2'd1, ADDR_TX_COUNT, 8'h00, 8'h00},
		'{2'd0, ADDR_CTRL, 8'h10, 8'h10},
		'{2'd1, ADDR_RX_DATA, 8'h7e, 8'h00},
		'{2'd1, ADDR_RX_DATA, 8'h55, 8'h00},
		'{2'd1, ADDR_RX_DATA, 8'ha3, 8'h00},
		'{2'd1, ADDR_RX_DATA, 8'h7e, 8'h00},
		'{2'd1, ADDR_RX_DATA, 8'h7e, 8'h00},
		'{2'd1, ADDR_CTRL, 8'h02, 8'h00},
		'{2'd0, ADDR_CTRL, 8'h22, 8'h22},
		'{2'd1, ADDR_RX_GO, 8'h28, 8'h00},
		'{2'd2, 16'h0000, 8'h50, 8'h00},
		'{2'd0, ADDR_CTRL, 8'h00, 8'h22},
		'{2'd0, ADDR_RX_DATA, 8'h55, 8'hff},
		'{2'd0, ADDR_RX_DATA, 8'ha3, 8'hff},
		'{2'd0, ADDR_CTRL, 8'h20, 8'h20}
	};

	// ==========================================
	// design
	hdlc_framing_assist i_hdlc_framing_assist (
		.clk      (clk),
		.resetn   (resetn),
		.addr     (addr),
		.data_in  (data_in),
		.wr_n     (wr_n),
		.rd_n     (rd_n),
		.data_out (data_out),
		.data_oe  (data_oe)
	);

	always #2 clk = ~clk;

	// ==========================================
	// bus tasks
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		data_in = d;
		wr_n = 1'b0;
		@(negedge clk);
		wr_n = 1'b1;
		@(negedge clk);
	endtask : bus_wr

	task automatic bus_rd(input logic [15:0] a, output logic [7:0] q, output logic oe);
		@(negedge clk);
		addr = a;
		rd_n = 1'b0;
		@(negedge clk);
		@(negedge clk);
		q = data_out;
		oe = data_oe;
		rd_n = 1'b1;
	endtask : bus_rd

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] q;
		logic       oe;
		bus_rd(a, q, oe);
		`CHK(oe, 1'b1)
		`CHK(q & m, e & m)
	endtask : rd_chk

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ 16'h8408) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	task automatic summarize();
		if (fail_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	// ==========================================
	// watchdog
	initial begin
		#20000;
		fail_count++;
		summarize();
	end

	// ==========================================
	// main sequence
	initial begin
		logic [7:0]  q;
		logic        oe;
		logic [15:0] crc;
		logic [7:0]  frame [3];
		clk = 1'b0;
		resetn = 1'b0;
		addr = 16'h0000;
		data_in = 8'h00;
		wr_n = 1'b1;
		rd_n = 1'b1;
		fail_count = 0;
		compares = 0;
		frame = '{8'h01, 8'h02, 8'h03};
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		repeat (2) @(negedge clk);

		foreach (rows[i]) begin
			case (rows[i].kind)
				2'd1: bus_wr(rows[i].a, rows[i].d);
				2'd2: repeat (rows[i].d) @(negedge clk);
				2'd3: begin
					bus_rd(rows[i].a, q, oe);
					`CHK(oe, 1'b0)
				end
				default: rd_chk(rows[i].a, rows[i].m, rows[i].d);
			endcase
		end

		// threshold select and level bit
		bus_wr(ADDR_CTRL, 8'h00);
		repeat (10) bus_wr(ADDR_TX_DATA, 8'h00);
		rd_chk(ADDR_CTRL, 8'h08, 8'h08);
		bus_wr(ADDR_TX_DATA, 8'h00);
		rd_chk(ADDR_CTRL, 8'h09, 8'h01);
		bus_wr(ADDR_CTRL, 8'h04);
		rd_chk(ADDR_CTRL, 8'h0c, 8'h0c);
		repeat (5) bus_wr(ADDR_TX_DATA, 8'h00);
		rd_chk(ADDR_CTRL, 8'h09, 8'h01);
		bus_wr(ADDR_CTRL, 8'h44);
		bus_wr(ADDR_CTRL, 8'h04);
		rd_chk(ADDR_CTRL, 8'h28, 8'h28);

		// short runs: two idle flag bits out, three bits in
		bus_wr(ADDR_TX_COUNT, 8'h02);
		repeat (8) @(negedge clk);
		rd_chk(ADDR_CTRL, 8'h11, 8'h10);
		rd_chk(ADDR_TX_DATA, 8'h03, 8'h02);
		bus_wr(ADDR_RX_GO, 8'h03);
		repeat (8) @(negedge clk);
		rd_chk(ADDR_CTRL, 8'h20, 8'h20);

		// check unit good frame
		crc = 16'hffff;
		foreach (frame[i]) begin
			bus_wr(ADDR_CHK_DATA, frame[i]);
			crc = crc_step(crc, frame[i]);
			rd_chk(ADDR_CHK_STAT, 8'h01, 8'h01);
			rd_chk(ADDR_CHK_DATA, 8'hff, frame[i]);
			rd_chk(ADDR_CHK_STAT, 8'h01, 8'h00);
		end
		rd_chk(ADDR_CHK_LOW, 8'hff, ~crc[7:0]);
		rd_chk(ADDR_CHK_HIGH, 8'hff, ~crc[15:8]);
		bus_wr(ADDR_CHK_DATA, ~crc[7:0]);
		bus_wr(ADDR_CHK_DATA, ~crc[15:8]);
		bus_wr(ADDR_CHK_DATA, FLAG_OCTET);
		rd_chk(ADDR_CHK_STAT, 8'h06, 8'h06);
		bus_wr(ADDR_CHK_DATA, 8'h11);
		rd_chk(ADDR_CHK_STAT, 8'h02, 8'h02);
		bus_wr(ADDR_CHK_STAT, 8'h80);
		rd_chk(ADDR_CHK_STAT, 8'h0b, 8'h08);

		// check unit bad frame
		bus_wr(ADDR_CHK_DATA, 8'h11);
		bus_wr(ADDR_CHK_DATA, 8'h22);
		bus_wr(ADDR_CHK_DATA, FLAG_OCTET);
		rd_chk(ADDR_CHK_STAT, 8'h06, 8'h02);

		// global reset after threshold select clears thr_sel and bus outputs
		bus_wr(ADDR_CTRL, 8'h04);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(data_out, 8'h00)
		`CHK(data_oe, 1'b0)
		resetn = 1'b1;
		repeat (2) @(negedge clk);
		rd_chk(ADDR_CTRL, 8'h2c, 8'h28);
		summarize();
	end
endmodule : tb_top
